// *** verilog/pmbcfg_pkg.sv ***
package pmbcfg_pkg;
  // Command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_USER_STORAGE = 8'hd0;
  localparam logic [7:0] CMD_DELAY_SELECT = 8'hd1;
  localparam logic [7:0] CMD_MODE_SELECT = 8'hd2;
  localparam logic [7:0] CMD_FREQ_SELECT = 8'hd3;
  // Supported bits per register
  localparam logic [7:0] USER_MASK = 8'h3f;
  localparam logic [7:0] DELAY_MASK = 8'h3f;
  localparam logic [7:0] MODE_MASK = 8'h0f;
  localparam logic [7:0] FREQ_MASK = 8'h07;
  // Reset values
  localparam logic [7:0] USER_RESET = 8'h00;
  localparam logic [7:0] DELAY_RESET = 8'h12;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] FREQ_RESET = 8'h02;
  // Field positions
  localparam int PGD_LSB = 3;
  localparam int POD_LSB = 0;
  localparam int SST_LSB = 2;
  localparam int UV_LATCH_BIT = 1;
  localparam int CM_BIT = 0;
  localparam int FREQ_LSB = 0;
  // Fault flag positions
  localparam int FL_OV = 0;
  localparam int FL_UV = 1;
  localparam int FL_OC = 2;
  localparam int FL_VIN = 3;
  localparam int FL_TEMP = 4;
  localparam int FL_CML = 5;
  localparam int NFLAGS = 6;
  // Timing, in microseconds unless named otherwise
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PGD_BASE_US = 256;
  localparam int PGD_MAX_US = 131072;
  localparam int POD_OFFSET_US = 100;
  localparam int POD_BASE_US = 256;
  localparam int SST_BASE_US = 1000;
  localparam int HICCUP_BASE_US = 8960;
  localparam int HICCUP_SST_MULT = 7;
  localparam int TW = 18;

  typedef enum logic [2:0] {
    ST_OFF, ST_POWER_ON_DELAY, ST_SOFT_START, ST_POWER_GOOD_DELAY,
    ST_REGULATING, ST_HICCUP, ST_LATCHED_OFF
  } pmbcfg_state_t;

  function automatic logic [TW-1:0] pod_us(input logic [2:0] code);
    pod_us = TW'(POD_OFFSET_US + (POD_BASE_US << code));
  endfunction

  function automatic logic [TW-1:0] pgd_us(input logic [2:0] code);
    pgd_us = (code == 3'h7) ? TW'(PGD_MAX_US) : TW'(PGD_BASE_US << code);
  endfunction

  function automatic logic [TW-1:0] sst_us(input logic [1:0] code);
    sst_us = TW'(SST_BASE_US << code);
  endfunction

  function automatic logic [TW-1:0] hiccup_us(input logic [1:0] code);
    hiccup_us = TW'(HICCUP_BASE_US + HICCUP_SST_MULT * (SST_BASE_US << code));
  endfunction
endpackage

// *** verilog/pmbcfg_link_bridge.sv ***
`timescale 1ns/100ps
module pmbcfg_link_bridge (
  // Link domain
  input wire logic i_link_clk,
  input wire logic i_link_rst_n,
  input wire logic i_link_valid,
  input wire logic i_link_write,
  input wire logic [7:0] i_link_cmd,
  input wire logic [7:0] i_link_wdata,
  output logic o_link_ready,
  output logic [15:0] o_link_rdata,
  output logic o_link_rvalid,
  // Core domain
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  output logic o_req,
  output logic o_write,
  output logic [7:0] o_cmd,
  output logic [7:0] o_wdata,
  input wire logic [15:0] i_rdata
);
  logic req_tgl;
  logic ack_s1;
  logic ack_s2;
  logic ack_seen;
  logic hold_write;
  logic [7:0] hold_cmd;
  logic [7:0] hold_wdata;
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic ack_tgl;
  logic [15:0] rdata_hold;

  // One request in flight; the held words stay put until the ack returns
  assign o_link_ready = (req_tgl == ack_s2);

  always_ff @(posedge i_link_clk) begin
    if (!i_link_rst_n) begin
      req_tgl <= 1'b0;
      hold_write <= 1'b0;
      hold_cmd <= 8'h00;
      hold_wdata <= 8'h00;
    end else if (i_link_valid && o_link_ready) begin
      req_tgl <= ~req_tgl;
      hold_write <= i_link_write;
      hold_cmd <= i_link_cmd;
      hold_wdata <= i_link_wdata;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!i_link_rst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_seen <= 1'b0;
      o_link_rdata <= 16'h0000;
      o_link_rvalid <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_seen <= ack_s2;
      o_link_rvalid <= ack_s2 != ack_seen;
      if (ack_s2 != ack_seen) begin
        o_link_rdata <= rdata_hold;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      ack_tgl <= 1'b0;
      rdata_hold <= 16'h0000;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      if (req_s2 != req_s3) begin
        ack_tgl <= ~ack_tgl;
        rdata_hold <= i_rdata;
      end
    end
  end

  // Held words change with the toggle and are stable for at least one core edge before it lands in req_s2
  assign o_req = req_s2 != req_s3;
  assign o_write = hold_write;
  assign o_cmd = hold_cmd;
  assign o_wdata = hold_wdata;
endmodule

// *** verilog/pmbcfg_top.sv ***
`timescale 1ns/100ps
module pmbcfg_top #(
  parameter int P_US_CYCLES = pmbcfg_pkg::US_CYCLES
) (
  // Clocks and resets
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_link_rst_n,
  // Command link
  input wire logic i_link_valid,
  input wire logic i_link_write,
  input wire logic [7:0] i_link_cmd,
  input wire logic [7:0] i_link_wdata,
  output logic o_link_ready,
  output logic [15:0] o_link_rdata,
  output logic o_link_rvalid,
  // Converter pins and fault conditions
  input wire logic i_enable_pin,
  input wire logic i_fault_vout_ov,
  input wire logic i_fault_vout_uv,
  input wire logic i_fault_iout_oc,
  input wire logic i_fault_vin_uv,
  input wire logic i_fault_temp,
  // Alert, open drain
  output logic o_alert_out,
  output logic o_alert_oe,
  // Converter control
  output logic o_power_good,
  output logic o_switching_enable,
  output logic o_soft_start_active,
  output logic o_forced_continuous,
  output logic [2:0] o_frequency_code,
  output logic [1:0] o_soft_start_time
);
  import pmbcfg_pkg::*;

  logic req;
  logic req_write;
  logic [7:0] req_cmd;
  logic [7:0] req_wdata;
  logic [15:0] rdata;

  pmbcfg_link_bridge u_bridge (
    .i_link_clk(i_link_clk),
    .i_link_rst_n(i_link_rst_n),
    .i_link_valid(i_link_valid),
    .i_link_write(i_link_write),
    .i_link_cmd(i_link_cmd),
    .i_link_wdata(i_link_wdata),
    .o_link_ready(o_link_ready),
    .o_link_rdata(o_link_rdata),
    .o_link_rvalid(o_link_rvalid),
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .o_req(req),
    .o_write(req_write),
    .o_cmd(req_cmd),
    .o_wdata(req_wdata),
    .i_rdata(rdata)
  );

  // Pin synchronisers: first stage read only by second
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic en;
  logic en_prev;
  logic [NFLAGS-2:0] cond;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      en_prev <= 1'b0;
    end else begin
      pin_s1 <= {i_enable_pin, i_fault_temp, i_fault_vin_uv, i_fault_iout_oc,
                 i_fault_vout_uv, i_fault_vout_ov};
      pin_s2 <= pin_s1;
      en_prev <= pin_s2[5];
    end
  end

  assign en = pin_s2[5];
  assign cond = pin_s2[4:0];

  // Register file
  logic [7:0] user_storage;
  logic [7:0] delay_timing_select;
  logic [7:0] mode_and_softstart_select;
  logic [7:0] switching_frequency_select;
  logic [7:0] nvm [4];
  logic wr_ok;
  logic clear_cmd;
  logic cml_event;

  always_comb begin
    wr_ok = 1'b1;
    unique case (req_cmd)
      CMD_USER_STORAGE, CMD_DELAY_SELECT, CMD_MODE_SELECT,
      CMD_FREQ_SELECT, CMD_CLEAR_FAULTS, CMD_STORE_ALL,
      CMD_RESTORE_ALL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  assign clear_cmd = req && req_write && req_cmd == CMD_CLEAR_FAULTS;
  // Unknown commands and reads of write-only commands count as link faults
  assign cml_event = req && (req_write ? !wr_ok :
    !(req_cmd == CMD_STATUS_BYTE || req_cmd == CMD_STATUS_WORD ||
      req_cmd[7:2] == CMD_USER_STORAGE[7:2]));

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      user_storage <= USER_RESET;
      delay_timing_select <= DELAY_RESET;
      mode_and_softstart_select <= MODE_RESET;
      switching_frequency_select <= FREQ_RESET;
    end else if (req && req_write) begin
      unique case (req_cmd)
        CMD_USER_STORAGE: user_storage <= req_wdata & USER_MASK;
        CMD_DELAY_SELECT: delay_timing_select <= req_wdata & DELAY_MASK;
        CMD_MODE_SELECT: mode_and_softstart_select <= req_wdata & MODE_MASK;
        CMD_FREQ_SELECT: switching_frequency_select <= req_wdata & FREQ_MASK;
        CMD_RESTORE_ALL: begin
          user_storage <= nvm[0];
          delay_timing_select <= nvm[1];
          mode_and_softstart_select <= nvm[2];
          switching_frequency_select <= nvm[3];
        end
        default: ;
      endcase
    end
  end

  // Flops stand in for the storage cells; a real part keeps them over power loss
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      nvm[0] <= USER_RESET;
      nvm[1] <= DELAY_RESET;
      nvm[2] <= MODE_RESET;
      nvm[3] <= FREQ_RESET;
    end else if (req && req_write && req_cmd == CMD_STORE_ALL) begin
      nvm[0] <= user_storage;
      nvm[1] <= delay_timing_select;
      nvm[2] <= mode_and_softstart_select;
      nvm[3] <= switching_frequency_select;
    end
  end

  // Fault flags
  logic [NFLAGS-1:0] flags;
  logic [NFLAGS-1:0] next_flags;
  logic en_rise;

  assign en_rise = en && !en_prev;

  always_comb begin
    next_flags = flags;
    if (clear_cmd || en_rise) begin
      next_flags = '0;
    end
    // Set wins over clear, so a live fault re-latches at once
    next_flags[FL_CML-1:0] = next_flags[FL_CML-1:0] | cond;
    next_flags[FL_CML] = next_flags[FL_CML] | cml_event;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_alert_oe <= 1'b0;
    end else begin
      o_alert_oe <= |next_flags;
    end
  end

  assign o_alert_out = 1'b0;

  // Microsecond tick
  logic [15:0] pre_cnt;
  logic us_tick;

  assign us_tick = pre_cnt == 16'(P_US_CYCLES - 1);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || us_tick) begin
      pre_cnt <= 16'h0000;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
    end
  end

  // Start-up sequencer
  pmbcfg_state_t state;
  pmbcfg_state_t next_state;
  logic [TW-1:0] timer;
  logic [TW-1:0] next_timer;
  logic [1:0] sst_code;
  logic uv_now;

  assign sst_code = mode_and_softstart_select[SST_LSB +: 2];
  assign uv_now = cond[FL_UV];

  always_comb begin
    next_state = state;
    next_timer = (us_tick && timer != '0) ? timer - TW'(1) : timer;
    unique case (state)
      ST_OFF: begin
        if (en) begin
          next_state = ST_POWER_ON_DELAY;
          next_timer = pod_us(delay_timing_select[POD_LSB +: 3]);
        end
      end
      ST_POWER_ON_DELAY: begin
        if (timer == '0) begin
          next_state = ST_SOFT_START;
          next_timer = sst_us(sst_code);
        end
      end
      ST_SOFT_START: begin
        if (timer == '0) begin
          next_state = ST_POWER_GOOD_DELAY;
          next_timer = pgd_us(delay_timing_select[PGD_LSB +: 3]);
        end
      end
      ST_POWER_GOOD_DELAY: begin
        if (timer == '0) begin
          next_state = ST_REGULATING;
        end
      end
      ST_REGULATING: ;
      ST_HICCUP: begin
        if (timer == '0) begin
          next_state = ST_SOFT_START;
          next_timer = sst_us(sst_code);
        end
      end
      ST_LATCHED_OFF: ;
    endcase
    // Undervoltage is only judged once the ramp is complete
    if ((state == ST_POWER_GOOD_DELAY || state == ST_REGULATING) && uv_now) begin
      if (mode_and_softstart_select[UV_LATCH_BIT]) begin
        next_state = ST_LATCHED_OFF;
      end else begin
        next_state = ST_HICCUP;
        next_timer = hiccup_us(sst_code);
      end
    end
    if (!en) begin
      next_state = ST_OFF;
      next_timer = '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state <= ST_OFF;
      timer <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // Converter control outputs
  logic running;

  assign running = next_state == ST_SOFT_START || next_state == ST_POWER_GOOD_DELAY ||
                   next_state == ST_REGULATING;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_power_good <= 1'b0;
      o_switching_enable <= 1'b0;
      o_soft_start_active <= 1'b0;
      o_forced_continuous <= 1'b0;
    end else begin
      o_power_good <= next_state == ST_REGULATING;
      o_switching_enable <= running;
      o_soft_start_active <= next_state == ST_SOFT_START;
      // Discontinuous through the ramp, forced continuous only afterwards
      o_forced_continuous <= running && next_state != ST_SOFT_START &&
                             mode_and_softstart_select[CM_BIT];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_frequency_code <= FREQ_RESET[2:0];
      o_soft_start_time <= MODE_RESET[SST_LSB +: 2];
    end else begin
      o_frequency_code <= switching_frequency_select[FREQ_LSB +: 3];
      o_soft_start_time <= sst_code;
    end
  end

  // Read data
  logic [7:0] status_lo;
  logic [7:0] status_hi;

  always_comb begin
    status_lo = 8'h00;
    status_hi = 8'h00;
    status_lo[6] = !o_switching_enable;
    status_lo[5] = flags[FL_OV];
    status_lo[4] = flags[FL_OC];
    status_lo[3] = flags[FL_VIN];
    status_lo[2] = flags[FL_TEMP];
    status_lo[1] = flags[FL_CML];
    status_hi[7] = flags[FL_OV] | flags[FL_UV];
    status_hi[6] = flags[FL_OC];
    status_hi[5] = flags[FL_VIN];
    status_hi[3] = !o_power_good;
  end

  always_comb begin
    unique case (req_cmd)
      CMD_STATUS_BYTE: rdata = {8'h00, status_lo};
      CMD_STATUS_WORD: rdata = {status_hi, status_lo};
      CMD_USER_STORAGE: rdata = {8'h00, user_storage};
      CMD_DELAY_SELECT: rdata = {8'h00, delay_timing_select};
      CMD_MODE_SELECT: rdata = {8'h00, mode_and_softstart_select};
      CMD_FREQ_SELECT: rdata = {8'h00, switching_frequency_select};
      default: rdata = 16'h0000;
    endcase
  end
endmodule

// *** tb/pmbcfg_top_sva.sv ***
`timescale 1ns/100ps
module pmbcfg_top_sva #(
  parameter int P_US_CYCLES = 100
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Inputs watched
  input wire logic i_enable_pin,
  input wire logic i_fault_vout_ov,
  input wire logic i_fault_temp,
  // Outputs watched
  input wire logic o_link_ready,
  input wire logic o_alert_oe,
  input wire logic o_power_good,
  input wire logic o_switching_enable,
  input wire logic o_soft_start_active,
  input wire logic o_forced_continuous,
  input wire logic [2:0] o_frequency_code,
  input wire logic [1:0] o_soft_start_time
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic [2:0] busy_q;
  logic [3:0] en_age;
  logic en_q;
  logic link_busy;
  // Ready is link side; a short history covers the crossing lag
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) busy_q <= 3'h0;
    else busy_q <= {busy_q[1:0], !o_link_ready};
  end
  always_ff @(posedge i_core_clk) begin
    en_q <= i_enable_pin;
    if (!i_rst_n) en_age <= 4'hf;
    else if (i_enable_pin && !en_q) en_age <= 4'h0;
    else if (en_age != 4'hf) en_age <= en_age + 4'h1;
  end
  assign link_busy = !o_link_ready || (busy_q != 3'h0);
  a_alert_on_fault: assert property ($rose(i_fault_vout_ov) ##1 i_fault_vout_ov [*2] |-> ##[1:3] o_alert_oe)
    else $error("alert missing after overvoltage");
  a_alert_persist: assert property (i_fault_temp [*6] |-> o_alert_oe)
    else $error("alert low while fault persists");
  a_alert_release: assert property ($fell(o_alert_oe) |-> link_busy || en_age < 4'h8)
    else $error("alert released without clear or enable cycle");
  a_pg_after_ss: assert property ($rose(o_power_good) |-> $past(o_switching_enable) && !$past(o_soft_start_active))
    else $error("power good not preceded by delay phase");
  a_ss_before_pg: assert property ($rose(o_soft_start_active) |-> !$past(o_power_good))
    else $error("soft start entered from power good");
  a_enable_off: assert property (!i_enable_pin [*5] |-> !o_switching_enable && !o_power_good)
    else $error("converter runs with enable low");
  a_fcc_not_ss: assert property (o_soft_start_active |-> !o_forced_continuous)
    else $error("forced continuous during soft start");
  a_fcc_running: assert property ($rose(o_forced_continuous) |-> $past(o_switching_enable))
    else $error("forced continuous while stopped");
  a_ss_in_sw: assert property (o_soft_start_active |-> o_switching_enable)
    else $error("soft start without switching");
  a_freq_hold: assert property ($changed(o_frequency_code) |-> link_busy)
    else $error("frequency code changed without command");
  a_sst_hold: assert property ($changed(o_soft_start_time) |-> link_busy)
    else $error("soft start time changed without command");
endmodule

// *** tb/pmbcfg_host_model.sv ***
`timescale 1ns/100ps
module pmbcfg_host_model (
  // Link clock
  input wire logic i_link_clk,
  // Request
  output logic o_link_valid,
  output logic o_link_write,
  output logic [7:0] o_link_cmd,
  output logic [7:0] o_link_wdata,
  // Answer
  input wire logic i_link_ready,
  input wire logic [15:0] i_link_rdata,
  input wire logic i_link_rvalid
);
  initial begin
    o_link_valid = 1'b0;
    o_link_write = 1'b0;
    o_link_cmd = 8'h00;
    o_link_wdata = 8'h00;
  end
  // One request outstanding; answer taken at the edge rvalid is seen
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
      output logic [15:0] r, output bit ok);
    int n;
    n = 0;
    r = 16'h0000;
    @(posedge i_link_clk);
    o_link_valid <= 1'b1;
    o_link_write <= w;
    o_link_cmd <= c;
    o_link_wdata <= d;
    do begin
      @(posedge i_link_clk);
      n++;
    end while (i_link_ready !== 1'b1 && n < 50);
    // Released lines show a fresh pattern, never the stale value
    o_link_valid <= 1'b0;
    o_link_write <= ~w;
    o_link_cmd <= ~c;
    o_link_wdata <= ~d;
    while (i_link_rvalid !== 1'b1 && n < 100) begin
      @(posedge i_link_clk);
      n++;
    end
    ok = n < 100;
    r = i_link_rdata;
  endtask
endmodule

// *** tb/pmbcfg_top_test.sv ***
`timescale 1ns/100ps
module pmbcfg_top_test;
  import pmbcfg_pkg::*;
  localparam int P_US = 1;
  logic i_core_clk = 0, i_link_clk = 0, i_rst_n = 0, i_link_rst_n = 0, i_enable_pin = 0;
  logic [4:0] flt = 5'h00;
  logic [31:0] seed = 32'h53;
  logic i_link_valid, i_link_write, o_link_ready, o_link_rvalid, o_alert_out, o_alert_oe;
  logic [7:0] i_link_cmd, i_link_wdata;
  logic [15:0] o_link_rdata;
  logic o_power_good, o_switching_enable, o_soft_start_active, o_forced_continuous;
  logic [2:0] o_frequency_code;
  logic [1:0] o_soft_start_time;
  wire alert_line_n = o_alert_oe ? o_alert_out : 1'b1;
  int fail_count, num_checks;
  logic [7:0] msk [4] = '{USER_MASK, DELAY_MASK, MODE_MASK, FREQ_MASK};
  logic [7:0] dflt [4] = '{8'h00, 8'h12, 8'h00, 8'h02};
  logic [15:0] stat [6] = '{16'h8860, 16'h8840, 16'h4850, 16'h2848, 16'h0844, 16'h0842};
  logic [7:0] val [4];
  initial forever #5 i_core_clk = ~i_core_clk;
  initial begin
    #1.7;
    forever #3 i_link_clk = ~i_link_clk;
  end
  pmbcfg_top #(.P_US_CYCLES(P_US)) uut (.i_core_clk, .i_rst_n, .i_link_clk, .i_link_rst_n,
    .i_link_valid, .i_link_write, .i_link_cmd, .i_link_wdata, .o_link_ready, .o_link_rdata,
    .o_link_rvalid, .i_enable_pin, .i_fault_vout_ov(flt[0]), .i_fault_vout_uv(flt[1]),
    .i_fault_iout_oc(flt[2]), .i_fault_vin_uv(flt[3]), .i_fault_temp(flt[4]), .o_alert_out,
    .o_alert_oe, .o_power_good, .o_switching_enable, .o_soft_start_active,
    .o_forced_continuous, .o_frequency_code, .o_soft_start_time);
  pmbcfg_host_model host (.i_link_clk, .o_link_valid(i_link_valid), .o_link_write(i_link_write),
    .o_link_cmd(i_link_cmd), .o_link_wdata(i_link_wdata), .i_link_ready(o_link_ready),
    .i_link_rdata(o_link_rdata), .i_link_rvalid(o_link_rvalid));
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic pick(input int k);
    case (k)
      0: return o_soft_start_active;
      1: return o_power_good;
      2: return o_switching_enable;
      default: return !alert_line_n;
    endcase
  endfunction
  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_time(input int n, input int lo, input int hi);
    num_checks++;
    if (n < lo || n > hi) begin
      fail_count++;
      $display("[FAIL] %0t took %0d cycles, window %0d..%0d", $time, n, lo, hi);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
      output logic [15:0] r);
    bit ok;
    host.xfer(w, c, d, r, ok);
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t no answer to command %h", $time, c);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [15:0] r;
    xfer(1'b1, c, d, r);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] r;
    xfer(1'b0, c, 8'h00, r);
    chk_val(r, exp);
  endtask
  task automatic wait_lvl(input int k, input logic lvl, input int lim, output int n);
    n = 0;
    while (pick(k) !== lvl && n < lim) begin
      @(posedge i_core_clk);
      n++;
    end
  endtask
  task automatic pulse(input int k);
    @(posedge i_core_clk);
    flt[k] <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    flt <= 5'h00;
  endtask
  task automatic run_up(input logic [2:0] power_on_delay, input logic [1:0] soft_start_time, input logic [2:0] power_good_delay,
      input logic fc);
    int n, e;
    e = (100 + (256 << power_on_delay)) * P_US;
    wait_lvl(0, 1'b1, e + 20, n);
    chk_time(n, e - 2, e + 6);
    e = (1000 << soft_start_time) * P_US;
    wait_lvl(0, 1'b0, e + 20, n);
    chk_time(n, e - 2, e + 4);
    e = (256 << power_good_delay) * P_US;
    wait_lvl(1, 1'b1, e + 20, n);
    chk_time(n, e - 2, e + 4);
    chk_val({15'h0, o_forced_continuous}, {15'h0, fc});
  endtask
  initial begin
    // Longest path is about 60k core cycles: three ramps and two hiccup spans
    #800000;
    fail_count++;
    end_sim();
  end
  initial begin
    logic [2:0] power_on_delay, power_good_delay;
    logic [1:0] soft_start_time;
    logic [7:0] r8, c;
    int n, e;
    fail_count = 0;
    num_checks = 0;
    repeat (12) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(posedge i_link_clk);
    i_link_rst_n <= 1'b1;
    repeat (4) @(posedge i_link_clk);
    repeat (4) @(posedge i_core_clk);
    chk_val({13'h0, o_frequency_code}, 16'h0002);
    chk_val({14'h0, o_soft_start_time}, 16'h0000);
    for (int i = 0; i < 4; i++) rd(8'(CMD_USER_STORAGE + i), {8'h00, dflt[i]});
    // All ones first, so unsupported bits are seen to drop
    for (int k = 0; k < 12; k++) begin
      r8 = (k < 4) ? 8'hff : rnd8();
      c = 8'(CMD_USER_STORAGE + k % 4);
      val[k % 4] = r8;
      wr(c, r8);
      rd(c, {8'h00, r8 & msk[k % 4]});
    end
    @(posedge i_core_clk);
    chk_val({13'h0, o_frequency_code}, {13'h0, val[3][2:0]});
    chk_val({14'h0, o_soft_start_time}, {14'h0, val[2][3:2]});
    wr(CMD_USER_STORAGE, 8'h2a);
    wr(CMD_STORE_ALL, 8'h00);
    wr(CMD_USER_STORAGE, 8'h15);
    wr(CMD_RESTORE_ALL, 8'h00);
    rd(CMD_USER_STORAGE, 16'h002a);
    rd(CMD_STATUS_WORD, 16'h0840);
    for (int k = 0; k < 6; k++) begin
      if (k == 1) continue;
      if (k < 5) pulse(k);
      else rd(8'h55, 16'h0000);
      wait_lvl(3, 1'b1, 20, n);
      chk_time(n, 0, 19);
      repeat (30) @(posedge i_core_clk);
      rd(CMD_STATUS_WORD, stat[k]);
      wr(CMD_CLEAR_FAULTS, 8'h00);
      wait_lvl(3, 1'b0, 10, n);
      chk_time(n, 0, 9);
      rd(CMD_STATUS_BYTE, 16'h0040);
    end
    @(posedge i_core_clk);
    flt[4] <= 1'b1;
    wait_lvl(3, 1'b1, 20, n);
    wr(CMD_CLEAR_FAULTS, 8'h00);
    repeat (3) @(posedge i_core_clk);
    chk_val({15'h0, alert_line_n}, 16'h0000);
    rd(CMD_STATUS_WORD, 16'h0844);
    @(posedge i_core_clk);
    flt <= 5'h00;
    repeat (4) @(posedge i_core_clk);
    wr(CMD_CLEAR_FAULTS, 8'h00);
    power_on_delay = 3'(rnd8() % 3);
    power_good_delay = 3'(rnd8() % 3);
    soft_start_time = 2'(rnd8() % 2);
    r8 = rnd8();
    wr(CMD_DELAY_SELECT, {2'b00, power_good_delay, power_on_delay});
    wr(CMD_MODE_SELECT, {4'h0, soft_start_time, 1'b0, r8[0]});
    @(posedge i_core_clk);
    i_enable_pin <= 1'b1;
    run_up(power_on_delay, soft_start_time, power_good_delay, r8[0]);
    pulse(1);
    wait_lvl(2, 1'b0, 20, n);
    chk_time(n, 0, 19);
    e = (8960 + 7 * (1000 << soft_start_time)) * P_US;
    wait_lvl(0, 1'b1, e + 20, n);
    chk_time(n, e - 2, e + 4);
    chk_val({15'h0, alert_line_n}, 16'h0000);
    wait_lvl(1, 1'b1, 20000, n);
    chk_time(n, 0, 19999);
    @(posedge i_core_clk);
    i_enable_pin <= 1'b0;
    repeat (6) @(posedge i_core_clk);
    chk_val({15'h0, o_switching_enable}, 16'h0000);
    wr(CMD_MODE_SELECT, {4'h0, soft_start_time, 1'b1, r8[0]});
    @(posedge i_core_clk);
    i_enable_pin <= 1'b1;
    // Ramp timing counts from the enable edge, so alert is checked after it
    run_up(power_on_delay, soft_start_time, power_good_delay, r8[0]);
    chk_val({15'h0, alert_line_n}, 16'h0001);
    pulse(1);
    wait_lvl(2, 1'b0, 20, n);
    chk_time(n, 0, 19);
    // Longer than a hiccup interval, so a restart would show here
    repeat (e + 20) @(posedge i_core_clk);
    chk_val({15'h0, o_switching_enable}, 16'h0000);
    end_sim();
  end
endmodule
bind pmbcfg_top pmbcfg_top_sva #(.P_US_CYCLES(P_US_CYCLES)) sva (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_enable_pin(i_enable_pin), .i_fault_vout_ov(i_fault_vout_ov),
  .i_fault_temp(i_fault_temp), .o_link_ready(o_link_ready), .o_alert_oe(o_alert_oe),
  .o_power_good(o_power_good), .o_switching_enable(o_switching_enable),
  .o_soft_start_active(o_soft_start_active), .o_forced_continuous(o_forced_continuous),
  .o_frequency_code(o_frequency_code), .o_soft_start_time(o_soft_start_time));
